// ### acs_pkg.sv
// Constants for the converter sequencer.
// Assumes a single system clock domain.
package acs_pkg;
   //==========================================================
   // Conversion timing in converter clock periods
   localparam int CONV_PERIODS   = 16;
   localparam int SAMPLE_PERIODS = 4;
   localparam int RESULT_W       = 12;
   localparam logic [11:0] FULL_SCALE = 12'hFFF;
   //==========================================================
   // Clock select codes
   localparam logic [2:0] CLK_DIV2  = 3'h0;
   localparam logic [2:0] CLK_DIV8  = 3'h1;
   localparam logic [2:0] CLK_DIV32 = 3'h2;
   localparam logic [2:0] CLK_DIV1  = 3'h4;
   localparam logic [2:0] CLK_DIV4  = 3'h5;
   localparam logic [2:0] CLK_DIV16 = 3'h6;
   //==========================================================
   // Reset values
   localparam logic [2:0] CLK_SEL_RESET = 3'h0;
   localparam logic [11:0] RESULT_RESET = 12'h000;
   //==========================================================
   // Sequencer states
   typedef enum logic [1:0]
   {
      ACS_IDLE   = 2'b00,
      ACS_ARMED  = 2'b01,
      ACS_SAMPLE = 2'b10,
      ACS_CONV   = 2'b11
   } acs_state_t;
endpackage : acs_pkg

// ### acs_clk_div.sv
// Converter clock enable generator.
// Assumes codes are latched by the caller during conversion.
`timescale 1ns/1ps
module acs_clk_div
(
   clk_sys,
   rst_b,
   run,
   clk_select,
   tick
);
   input  wire logic       clk_sys;
   input  wire logic       rst_b;
   input  wire logic       run;
   input  wire logic [2:0] clk_select;
   output      logic       tick;

   logic [4:0] count;

   //==========================================================
   // Terminal count for each legal code
   function automatic logic [4:0] acs_div_last(input logic [2:0] sel);
      unique case (sel)
         acs_pkg::CLK_DIV1:  acs_div_last = 5'h00;
         acs_pkg::CLK_DIV2:  acs_div_last = 5'h01;
         acs_pkg::CLK_DIV4:  acs_div_last = 5'h03;
         acs_pkg::CLK_DIV8:  acs_div_last = 5'h07;
         acs_pkg::CLK_DIV16: acs_div_last = 5'h0F;
         acs_pkg::CLK_DIV32: acs_div_last = 5'h1F;
         default:            acs_div_last = 5'h1F;
      endcase
   endfunction : acs_div_last

   always_ff @(posedge clk_sys)
   begin
      if (!rst_b || !run)
      begin
         count <= 5'h00;
         tick  <= 1'b0;
      end
      else if (count >= acs_div_last(clk_select))
      begin
         count <= 5'h00;
         tick  <= 1'b1;
      end
      else
      begin
         count <= count + 5'h01;
         tick  <= 1'b0;
      end
   end
endmodule : acs_clk_div

// ### acs_sar_core.sv
// Successive approximation register stepping.
// Assumes compare_high comes from the analog comparator.
`timescale 1ns/1ps
module acs_sar_core
(
   clk_sys,
   rst_b,
   clear,
   step,
   compare_high,
   trial,
   code
);
   input  wire logic        clk_sys;
   input  wire logic        rst_b;
   input  wire logic        clear;
   input  wire logic        step;
   input  wire logic        compare_high;
   output      logic [11:0] trial;
   output      logic [11:0] code;

   logic [11:0] mask;

   assign trial = code | mask;

   always_ff @(posedge clk_sys)
   begin
      if (!rst_b || clear)
      begin
         code <= acs_pkg::RESULT_RESET;
         mask <= 12'h800;
      end
      else if (step && (mask != 12'h000))
      begin
         if (compare_high)
            code <= code | mask;
         mask <= mask >> 1;
      end
   end
endmodule : acs_sar_core

// ### acs_seq.sv
// Top of the converter sequencer: start strobe, timing, result, flag.
// Assumes register bits arrive as plain synchronous ports and the
// comparator output is asynchronous.
`timescale 1ns/1ps
module acs_seq
(
   clk_sys,
   rst_b,
   start,
   channel_select,
   analog_pin_config,
   conv_clock_select,
   converter_power_off,
   global_irq_enable,
   multi_function_irq_enable,
   conv_irq_enable,
   stack_full,
   conv_irq_flag_clear,
   comparator_in,
   conversion_pending_n,
   conv_irq_flag,
   conv_irq_request,
   result_low,
   result_high,
   mux_channel,
   analog_pin_enable,
   converter_powered,
   sampling,
   dac_trial
);
   input  wire logic        clk_sys;
   input  wire logic        rst_b;
   input  wire logic        start;
   input  wire logic [1:0]  channel_select;
   input  wire logic [3:0]  analog_pin_config;
   input  wire logic [2:0]  conv_clock_select;
   input  wire logic        converter_power_off;
   input  wire logic        global_irq_enable;
   input  wire logic        multi_function_irq_enable;
   input  wire logic        conv_irq_enable;
   input  wire logic        stack_full;
   input  wire logic        conv_irq_flag_clear;
   input  wire logic        comparator_in;
   output      logic        conversion_pending_n;
   output      logic        conv_irq_flag;
   output      logic        conv_irq_request;
   output      logic [7:0]  result_low;
   output      logic [7:0]  result_high;
   output      logic [1:0]  mux_channel;
   output      logic [3:0]  analog_pin_enable;
   output      logic        converter_powered;
   output      logic        sampling;
   output      logic [11:0] dac_trial;

   acs_pkg::acs_state_t state;
   acs_pkg::acs_state_t next_state;

   logic        start_d;
   logic        cmp_s1;
   logic        cmp_s2;
   logic        cmp_s3;
   logic        cmp_clean;
   logic [2:0]  clk_sel_held;
   logic [4:0]  period_cnt;
   logic        tick;
   logic        running;
   logic        done;
   logic        power_ok;
   logic        sar_clear;
   logic        sar_step;
   logic [11:0] trial;
   logic [11:0] code;
   logic [11:0] final_code;
   logic        finish;
   logic        irq_enabled;

   //==========================================================
   // Power and pin routing
   assign power_ok = !converter_power_off
                     && (analog_pin_config != 4'h0);

   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         analog_pin_enable <= 4'h0;
         converter_powered <= 1'b0;
      end
      else
      begin
         analog_pin_enable <= analog_pin_config;
         converter_powered <= power_ok;
      end
   end

   //==========================================================
   // Comparator input synchroniser with agreement filter
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         cmp_s1    <= 1'b0;
         cmp_s2    <= 1'b0;
         cmp_s3    <= 1'b0;
         cmp_clean <= 1'b0;
      end
      else
      begin
         cmp_s1 <= comparator_in;
         cmp_s2 <= cmp_s1;
         cmp_s3 <= cmp_s2;
         if (cmp_s2 == cmp_s3)
            cmp_clean <= cmp_s3;
      end
   end

   //==========================================================
   // Sequencer
   assign running = (state == acs_pkg::ACS_SAMPLE)
                    || (state == acs_pkg::ACS_CONV);
   assign done = running && tick
                 && (period_cnt == 5'(acs_pkg::CONV_PERIODS - 1));

   always_comb
   begin
      next_state = state;
      unique case (state)
         acs_pkg::ACS_IDLE:
            if (start && !start_d && power_ok)
               next_state = acs_pkg::ACS_ARMED;
         // Start held high keeps converter in reset
         acs_pkg::ACS_ARMED:
            if (!power_ok)
               next_state = acs_pkg::ACS_IDLE;
            else if (!start)
               next_state = acs_pkg::ACS_SAMPLE;
         acs_pkg::ACS_SAMPLE:
            if (!power_ok)
               next_state = acs_pkg::ACS_IDLE;
            else if (start)
               next_state = acs_pkg::ACS_ARMED;
            else if (tick && period_cnt ==
                     5'(acs_pkg::SAMPLE_PERIODS - 1))
               next_state = acs_pkg::ACS_CONV;
         acs_pkg::ACS_CONV:
            if (!power_ok)
               next_state = acs_pkg::ACS_IDLE;
            else if (start)
               next_state = acs_pkg::ACS_ARMED;
            else if (done)
               next_state = acs_pkg::ACS_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         state   <= acs_pkg::ACS_IDLE;
         start_d <= 1'b0;
      end
      else
      begin
         state   <= next_state;
         start_d <= start;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_b || !running)
         period_cnt <= 5'h00;
      else if (tick)
         period_cnt <= period_cnt + 5'h01;
   end

   //==========================================================
   // Settings held during a conversion
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         clk_sel_held <= acs_pkg::CLK_SEL_RESET;
         mux_channel  <= 2'h0;
      end
      else if (!running)
      begin
         clk_sel_held <= conv_clock_select;
         mux_channel  <= channel_select;
      end
   end

   // Comparator path lags about six clocks
   // Ratios below eight leave SAR bits stale
   acs_clk_div u_div
   (
      .clk_sys    (clk_sys),
      .rst_b      (rst_b),
      .run        (running),
      .clk_select (clk_sel_held),
      .tick       (tick)
   );

   assign sar_clear = (state == acs_pkg::ACS_ARMED);
   assign sar_step  = tick && (state == acs_pkg::ACS_CONV);

   acs_sar_core u_sar
   (
      .clk_sys      (clk_sys),
      .rst_b        (rst_b),
      .clear        (sar_clear),
      .step         (sar_step),
      .compare_high (cmp_clean),
      .trial        (trial),
      .code         (code)
   );

   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         sampling  <= 1'b0;
         dac_trial <= acs_pkg::RESULT_RESET;
      end
      else
      begin
         sampling  <= (next_state == acs_pkg::ACS_SAMPLE);
         dac_trial <= trial;
      end
   end

   //==========================================================
   // Completion and interrupt gating
   // Last SAR step lands on the finishing edge
   assign finish      = done && !start && power_ok;
   assign final_code  = cmp_clean ? trial : code;
   assign irq_enabled = global_irq_enable
                        && multi_function_irq_enable
                        && conv_irq_enable;

   //==========================================================
   // Result, pending bit and request flag
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         result_low  <= 8'h00;
         result_high <= 8'h00;
      end
      else if (finish)
      begin
         result_low  <= final_code[7:0];
         result_high <= {4'h0, final_code[11:8]};
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
         conversion_pending_n <= 1'b1;
      // Arming or re-arming reopens the bit
      else if (next_state == acs_pkg::ACS_ARMED)
         conversion_pending_n <= 1'b1;
      else if (finish)
         conversion_pending_n <= 1'b0;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
         conv_irq_flag <= 1'b0;
      else if (finish)
         conv_irq_flag <= 1'b1;
      else if (conv_irq_flag_clear)
         conv_irq_flag <= 1'b0;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
         conv_irq_request <= 1'b0;
      else
         conv_irq_request <= conv_irq_flag && irq_enabled
                             && !stack_full;
   end
endmodule : acs_seq

// ### acs_analog_model.sv
// Analog side model: four channel levels facing the comparator.
// Assumes dac_trial and mux_channel come from the sequencer.
`timescale 1ns/1ps
module acs_analog_model
(
   mux_channel,
   dac_trial,
   levels,
   comparator_in
);
   input  wire logic [1:0]  mux_channel;
   input  wire logic [11:0] dac_trial;
   input  wire logic [47:0] levels;
   output      logic        comparator_in;
   //==========================================================
   // Comparator
   // No offset: comparator_in is high while level >= trial, so level c reads as code c
   assign comparator_in =
      levels[mux_channel*12 +: 12] >= dac_trial;
endmodule : acs_analog_model

// ### acs_seq_asserts.sv
// Port-level temporal checks for the converter sequencer.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module acs_seq_asserts
(
   input wire logic       clk_sys,
   input wire logic       rst_b,
   input wire logic       start,
   input wire logic [3:0] analog_pin_config,
   input wire logic       converter_power_off,
   input wire logic       global_irq_enable,
   input wire logic       multi_function_irq_enable,
   input wire logic       conv_irq_enable,
   input wire logic       stack_full,
   input wire logic       conv_irq_flag_clear,
   input wire logic       conversion_pending_n,
   input wire logic       conv_irq_flag,
   input wire logic       conv_irq_request,
   input wire logic [7:0] result_low,
   input wire logic [7:0] result_high,
   input wire logic [1:0] mux_channel,
   input wire logic [3:0] analog_pin_enable,
   input wire logic       converter_powered,
   input wire logic       sampling
);
   default clocking dc @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   //==========================================================
   // Sequences
   sequence s_arm;
      $rose(start) ##0 converter_powered;
   endsequence
   sequence s_done;
      $fell(conversion_pending_n);
   endsequence
   sequence s_sample_on;
      $rose(sampling);
   endsequence
   //==========================================================
   // Assertions
   AST_ARM: assert property (s_arm |=> conversion_pending_n)
      else $error("start rise did not raise pending bit");
   AST_DONE_FLAG: assert property (s_done |-> conv_irq_flag)
      else $error("completion without request flag");
   AST_SAMPLE: assert property (s_sample_on |-> sampling[*4])
      else $error("sampling phase too short");
   AST_FLAG_HOLD: assert property
      (conv_irq_flag && !conv_irq_flag_clear |=> conv_irq_flag)
      else $error("request flag dropped without clear");
   AST_REQ_GATE: assert property (conv_irq_request |->
      $past(conv_irq_flag && global_irq_enable && conv_irq_enable
      && multi_function_irq_enable && !stack_full))
      else $error("request without flag and enables");
   AST_REQ_SET: assert property (conv_irq_flag && global_irq_enable
      && multi_function_irq_enable && conv_irq_enable && !stack_full
      |=> conv_irq_request)
      else $error("enabled flag gave no request");
   AST_GLOBAL_OFF: assert property (!global_irq_enable
      |=> !conv_irq_request)
      else $error("request while global enable low");
   AST_POWER: assert property ((converter_power_off
      || analog_pin_config == 4'h0) |=> !converter_powered)
      else $error("converter powered when it should be off");
   AST_PINS: assert property ($past(rst_b) |->
      analog_pin_enable == $past(analog_pin_config))
      else $error("pin enables do not follow config");
   AST_NIBBLE: assert property (result_high[7:4] == 4'h0)
      else $error("result high byte exceeds twelve bits");
   AST_RES_HOLD: assert property (!conversion_pending_n
      && !$fell(conversion_pending_n) |-> $stable({result_high, result_low}))
      else $error("result changed outside completion");
   AST_MUX_HOLD: assert property (sampling && $past(sampling)
      |-> $stable(mux_channel))
      else $error("channel changed during sampling");
endmodule : acs_seq_asserts

bind acs_seq acs_seq_asserts u_asserts
(
   .clk_sys, .rst_b, .start, .analog_pin_config, .converter_power_off,
   .global_irq_enable, .multi_function_irq_enable, .conv_irq_enable,
   .stack_full, .conv_irq_flag_clear, .conversion_pending_n,
   .conv_irq_flag, .conv_irq_request, .result_low, .result_high,
   .mux_channel, .analog_pin_enable, .converter_powered, .sampling
);

// ### acs_seq_tb.sv
// Self-checking bench for the converter sequencer.
// Assumes acs_seq, the analog model and the checker bind are compiled.
`timescale 1ns/1ps
module acs_seq_tb;
   logic        clk_sys = 1'b0;
   logic        rst_b = 1'b0;
   logic        start = 1'b0;
   logic [1:0]  channel_select = 2'h0;
   logic [3:0]  analog_pin_config = 4'hF;
   logic [2:0]  conv_clock_select = 3'h0;
   logic        converter_power_off = 1'b0;
   logic [3:0]  irq_cfg = 4'h0;
   logic        conv_irq_flag_clear = 1'b0;
   // Fast ratios outrun the comparator path: full scale there
   logic [47:0] levels = {12'hFFF, 12'hA5C, 12'h3C1, 12'hFFF};
   logic        comparator_in, conversion_pending_n, conv_irq_flag;
   logic        conv_irq_request, converter_powered, sampling;
   logic [7:0]  result_low, result_high;
   logic [1:0]  mux_channel;
   logic [3:0]  analog_pin_enable;
   logic [11:0] dac_trial;
   logic [2:0]  codes [8] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h3, 3'h7};
   int          divs [8] = '{2, 8, 32, 1, 4, 16, 32, 32};
   int          error_cnt = 0, compares = 0, cyc, i;

   always #20 clk_sys = ~clk_sys;

   acs_seq u_dut
   (
      .clk_sys, .rst_b, .start, .channel_select, .analog_pin_config,
      .conv_clock_select, .converter_power_off,
      .global_irq_enable(irq_cfg[3]), .multi_function_irq_enable(irq_cfg[2]),
      .conv_irq_enable(irq_cfg[1]), .stack_full(irq_cfg[0]),
      .conv_irq_flag_clear, .comparator_in, .conversion_pending_n,
      .conv_irq_flag, .conv_irq_request, .result_low, .result_high,
      .mux_channel, .analog_pin_enable, .converter_powered, .sampling,
      .dac_trial
   );
   acs_analog_model u_analog
      (.mux_channel, .dac_trial, .levels, .comparator_in);

   //==========================================================
   // Tasks
   task automatic step;
      @(posedge clk_sys);
      #1;
   endtask : step
   task automatic cmp(input string what, input logic [15:0] exp,
                      input logic [15:0] got);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp
   task automatic wait_done;
      cyc = 0;
      while (conversion_pending_n !== 1'b0 && cyc < 3000)
      begin
         step;
         cyc++;
      end
      cmp("in_time", 16'h0, {15'h0, conversion_pending_n});
   endtask : wait_done
   task automatic convert(input logic [2:0] code, input logic [1:0] ch);
      conv_clock_select = code;
      channel_select = ch;
      step;
      start = 1'b1;
      step;
      start = 1'b0;
      wait_done;
   endtask : convert
   task automatic clear_flag;
      conv_irq_flag_clear = 1'b1;
      step;
      conv_irq_flag_clear = 1'b0;
      step;
   endtask : clear_flag
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : print_verdict

   //==========================================================
   // Tests
   initial
   begin
      repeat (20) step;
      rst_b = 1'b1;
      step;
      cmp("pend_rst", 16'h1, {15'h0, conversion_pending_n});
      cmp("res_rst", 16'h0, {result_high, result_low});
      for (i = 0; i < 8; i++)
      begin
         convert(codes[i], i[1:0]);
         cmp("span", 16'h1, {15'h0, cyc >= 16*divs[i]
            && cyc <= 16*divs[i] + 4});
         cmp("result", {4'h0, levels[i[1:0]*12 +: 12]},
            {result_high, result_low});
         cmp("mux", {14'h0, i[1:0]}, {14'h0, mux_channel});
         cmp("flag", 16'h1, {15'h0, conv_irq_flag});
         repeat (40) step;
         cmp("one_shot", 16'h0, {15'h0, conversion_pending_n});
         cmp("trial", {4'h0, levels[i[1:0]*12 +: 12]},
            {4'h0, dac_trial});
         clear_flag;
      end
      $display("divider and channel test done");
      for (i = 0; i < 16; i++)
      begin
         irq_cfg = i[3:0];
         convert(3'h4, 2'h1);
         step;
         cmp("irq_req", {15'h0, i[3:0] == 4'hE},
            {15'h0, conv_irq_request});
         repeat (5) step;
         cmp("sticky", 16'h1, {15'h0, conv_irq_flag});
         clear_flag;
         cmp("cleared", 16'h0, {15'h0, conv_irq_flag});
      end
      irq_cfg = 4'h0;
      $display("interrupt gating test done");
      convert(3'h2, 2'h2);
      cmp("pre_abort", {4'h0, levels[35:24]},
         {result_high, result_low});
      clear_flag;
      channel_select = 2'h0;
      start = 1'b1;
      step;
      start = 1'b0;
      repeat (30) step;
      cmp("sampling", 16'h1, {15'h0, sampling});
      start = 1'b1;
      repeat (600) step;
      cmp("abort_pend", 16'h1, {15'h0, conversion_pending_n});
      cmp("abort_flag", 16'h0, {15'h0, conv_irq_flag});
      start = 1'b0;
      wait_done;
      cmp("after_abort", {4'h0, levels[11:0]},
         {result_high, result_low});
      clear_flag;
      $display("abort test done");
      converter_power_off = 1'b1;
      repeat (2) step;
      cmp("pwr_off", 16'h0, {15'h0, converter_powered});
      start = 1'b1;
      step;
      start = 1'b0;
      repeat (100) step;
      cmp("ignored", 16'h0, {15'h0, conv_irq_flag});
      converter_power_off = 1'b0;
      analog_pin_config = 4'h0;
      repeat (2) step;
      cmp("no_pins", 16'h0, {12'h0, analog_pin_enable});
      cmp("pwr_pins", 16'h0, {15'h0, converter_powered});
      analog_pin_config = 4'h5;
      repeat (2) step;
      cmp("pins", 16'h5, {12'h0, analog_pin_enable});
      cmp("pwr_on", 16'h1, {15'h0, converter_powered});
      $display("power test done");
      print_verdict;
   end

   initial
   begin
      repeat (50000) @(posedge clk_sys);
      error_cnt++;
      print_verdict;
   end
endmodule : acs_seq_tb
